// >>> core/ssp_pkg.sv
package ssp_pkg;

  // ------------------------------------------------------------------
  // Register map (word aligned byte addresses)
  // ------------------------------------------------------------------
  localparam logic [11:0] SSP_ADDR_MODE_CTRL   = 12'h0000;
  localparam logic [11:0] SSP_ADDR_CTRL_STATUS = 12'h0004;
  localparam logic [11:0] SSP_ADDR_SHIFT_DATA  = 12'h0008;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int SSP_CS_IDLE_LVL   = 5;
  localparam int SSP_CS_CAP_EDGE   = 4;
  localparam int SSP_CS_BIT_ORDER  = 3;
  localparam int SSP_CS_SEL_EN     = 2;
  localparam int SSP_CS_WRITE_COLLISION_FLAG       = 1;
  localparam int SSP_CS_TRF        = 0;
  localparam int SSP_MC_MODE_LSB   = 5;
  localparam int SSP_MC_DEB_LSB    = 2;
  localparam int SSP_MC_ENABLE     = 1;
  localparam int SSP_MC_INCOMPLETE = 0;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] SSP_CTRL_STATUS_RST = 8'h00;
  localparam logic [2:0] SSP_MODE_RST        = 3'h7;

  // ------------------------------------------------------------------
  // Operating modes and timing
  // ------------------------------------------------------------------
  localparam logic [2:0] SSP_MODE_DIV4  = 3'h0;
  localparam logic [2:0] SSP_MODE_DIV16 = 3'h1;
  localparam logic [2:0] SSP_MODE_DIV64 = 3'h2;
  localparam logic [2:0] SSP_MODE_SUB   = 3'h3;
  localparam logic [2:0] SSP_MODE_TMR   = 3'h4;
  localparam logic [2:0] SSP_MODE_SLAVE = 3'h5;
  localparam logic [3:0] SSP_BITS_PER_XFER = 4'h8;

  typedef enum logic [1:0] {
    SSP_IDLE,
    SSP_LEAD,
    SSP_TRAIL
  } ssp_state_type;

  // Capture on rising edge when polarity and edge select agree
  function automatic logic ssp_capture_rising(input logic idle_lvl, input logic cap_edge);
    return idle_lvl == cap_edge;
  endfunction

endpackage

// >>> core/ssp_clkgen.sv
`timescale 1ns/10ps
module ssp_clkgen
  import ssp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [2:0] mode,
  input  wire logic       sub_tick,
  input  wire logic       tmr_tick,
  output logic            half_tick
);

  // ------------------------------------------------------------------
  // Half-period enable for the master serial clock
  // ------------------------------------------------------------------
  logic [4:0] cnt_q;
  logic       sys_tick;

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= 5'h00;
    end else begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  always_comb begin
    case (mode)
      SSP_MODE_DIV4:  sys_tick = cnt_q[0];
      SSP_MODE_DIV16: sys_tick = &cnt_q[2:0];
      SSP_MODE_DIV64: sys_tick = &cnt_q[4:0];
      default:        sys_tick = 1'b0;
    endcase
  end

  always_comb begin
    case (mode)
      SSP_MODE_SUB: half_tick = sub_tick;
      // One match per half period: clock runs at half the match rate
      SSP_MODE_TMR: half_tick = tmr_tick;
      default:      half_tick = sys_tick;
    endcase
  end

endmodule

// >>> core/ssp_shifter.sv
`timescale 1ns/10ps
module ssp_shifter
  import ssp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       load,
  input  wire logic [7:0] load_data,
  input  wire logic       shift,
  input  wire logic       msb_first,
  input  wire logic       in_bit,
  output logic            out_bit,
  output logic [7:0]      buf_data
);

  // ------------------------------------------------------------------
  // Internal shift buffer
  // ------------------------------------------------------------------
  logic [7:0] buf_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      buf_q <= 8'h00;
    end else if (load) begin
      buf_q <= load_data;
    end else if (shift) begin
      if (msb_first) begin
        buf_q <= {buf_q[6:0], in_bit};
      end else begin
        buf_q <= {in_bit, buf_q[7:1]};
      end
    end
  end

  assign out_bit  = msb_first ? buf_q[7] : buf_q[0];
  assign buf_data = buf_q;

endmodule

// >>> core/ssp_top.sv
// What the document asks of this block and of its software
// RL1 - Clock idles high when polarity bit zero
// RL2 - Capture rising when polarity equals edge select
// RL3 - Software sets polarity and edge before transfers
// RL4 - Bit order one means MSB first
// RL5 - Select pin used only when enabled
// RL6 - Data write during transfer dropped, collision
// RL7 - Collision flag cleared only by software
// RL8 - Complete flag sets at end, software clears
// RL9 - Master data write starts full duplex transfer
// RL10 - Slave shifts data on received clock
// RL11 - Master asserts select before any clock
// RL12 - Slave presents out bit before capture edge
// RL13 - Keeps running while its clock runs
// RL14 - Enabled idle: data input floats, output high
// RL15 - Idle clock driven in master, floats slave
// RL16 - Disabled releases all four pins
// RL17 - Master makes clock, slave uses external
// RL18 - Received byte copied only when complete
// RL19 - Software configures before setting enable
// RL20 - Software checks collision, waits, reads, clears
// RL21 - Two spare bits are plain storage
// RL22 - Mode field selects clock source or slave
// RL23 - Early select release sets incomplete, complete
// RL24 - Exactly eight bits per transfer
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/10ps
module ssp_top
  import ssp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sub_tick,
  input  wire logic        tmr_tick,
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe_n,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             sdo_oe_n,
  input  wire logic        select_n_in,
  output logic             pins_claimed
);

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [2:0]    mode_q;
  logic [1:0]    deb_q;
  logic          enable_q;
  logic          incomplete_q;
  logic [7:0]    cs_q;
  logic [7:0]    data_q;
  ssp_state_type state_q;
  logic [3:0]    bits_q;
  logic          sck_prev_q;
  logic          sel_prev_q;
  logic          lag_q;

  logic       wr_acc;
  logic       rd_acc;
  logic       is_master;
  logic       is_slave;
  logic       busy;
  logic       data_wr;
  logic       start;
  logic       half_tick;
  logic       sh_out;
  logic [7:0] sh_data;
  logic       sh_load;
  logic       sh_shift;
  logic       done;
  logic       abort;
  logic       sel_active;
  logic       cap_rise;
  logic       s_edge_lead;
  logic       s_edge_trail;
  logic       m_lead;
  logic       m_trail;

  assign wr_acc     = psel && penable && pwrite;
  assign rd_acc     = psel && penable && !pwrite;
  assign is_slave   = mode_q == SSP_MODE_SLAVE;
  assign is_master  = mode_q < SSP_MODE_SLAVE;
  assign busy       = state_q != SSP_IDLE;
  assign data_wr    = wr_acc && paddr == SSP_ADDR_SHIFT_DATA;
  assign cap_rise   = ssp_capture_rising(cs_q[SSP_CS_IDLE_LVL], cs_q[SSP_CS_CAP_EDGE]); // RL2
  assign sel_active = !cs_q[SSP_CS_SEL_EN] || !select_n_in; // RL5 RL11

  // ------------------------------------------------------------------
  // Clock source and shifter
  // ------------------------------------------------------------------
  ssp_clkgen u_clkgen ( // RL13
    .clk       (clk),
    .srst      (srst),
    .mode      (mode_q),
    .sub_tick  (sub_tick),
    .tmr_tick  (tmr_tick),
    .half_tick (half_tick)
  );

  // RL9 RL10: a data write arms the buffer in either role
  assign start   = data_wr && !busy && enable_q && (is_master || is_slave); // RL9
  assign sh_load = data_wr && !busy; // RL6

  // Slave edges seen on the external clock, sampled by the system clock
  assign s_edge_lead  = is_slave && busy && sel_active && (sck_prev_q != sck_in)
                        && ((sck_in == cap_rise));                  // RL10 RL17
  assign s_edge_trail = is_slave && busy && sel_active && (sck_prev_q != sck_in)
                        && ((sck_in != cap_rise));                  // RL12
  assign m_lead  = is_master && half_tick && lag_q && state_q == SSP_LEAD;   // RL17
  assign m_trail = is_master && half_tick && lag_q && state_q == SSP_TRAIL;
  assign sh_shift = (m_lead || s_edge_lead) && bits_q != 4'h0 && state_q == SSP_LEAD;
  assign done     = (is_slave && state_q == SSP_TRAIL && bits_q == 4'h0)      // RL24
                    || (m_trail && bits_q == 4'h0);
  assign abort    = is_slave && busy && enable_q && cs_q[SSP_CS_SEL_EN]
                    && !sel_prev_q && select_n_in;                  // RL23

  ssp_shifter u_shifter (
    .clk       (clk),
    .srst      (srst),
    .load      (sh_load),
    .load_data (pwdata[7:0]),
    .shift     (sh_shift),
    .msb_first (cs_q[SSP_CS_BIT_ORDER]), // RL4
    .in_bit    (sdi),
    .out_bit   (sh_out),
    .buf_data  (sh_data)
  );

  // ------------------------------------------------------------------
  // Transfer sequencer
  // ------------------------------------------------------------------
  // Lead edge captures and moves the next bit out in the same shift
  always_ff @(posedge clk) begin
    if (srst || !enable_q) begin
      state_q <= SSP_IDLE;
    end else begin
      case (state_q)
        SSP_IDLE: begin
          if (start) begin
            state_q <= cs_q[SSP_CS_CAP_EDGE] ? SSP_LEAD : SSP_TRAIL; // RL2
          end
        end
        SSP_LEAD: begin
          if (abort) begin
            state_q <= SSP_IDLE;
          end else if (done) begin
            state_q <= SSP_IDLE;
          end else if (m_lead || s_edge_lead) begin
            state_q <= SSP_TRAIL;
          end
        end
        SSP_TRAIL: begin
          if (abort || done) begin
            state_q <= SSP_IDLE;
          end else if (m_trail || s_edge_trail) begin
            state_q <= SSP_LEAD;
          end
        end
        default: state_q <= SSP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      bits_q <= 4'h0;
    end else if (start) begin
      bits_q <= SSP_BITS_PER_XFER; // RL24
    end else if (sh_shift) begin
      bits_q <= bits_q - 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sck_prev_q <= 1'b0;
      sel_prev_q <= 1'b1;
    end else begin
      sck_prev_q <= sck_in;
      sel_prev_q <= select_n_in;
    end
  end

  // Holds off the first master edge until the first bit is on the pin
  always_ff @(posedge clk) begin
    if (srst) begin
      lag_q <= 1'b0;
    end else begin
      lag_q <= busy;
    end
  end

  // ------------------------------------------------------------------
  // Master serial clock
  // ------------------------------------------------------------------
  // Moves with the sequencer so clock and data never race;
  // the closing trail edge is skipped when the line already idles
  always_ff @(posedge clk) begin
    if (srst) begin
      sck_out <= 1'b1;
    end else if (!is_master || !busy) begin
      sck_out <= !cs_q[SSP_CS_IDLE_LVL]; // RL1
    end else if (m_lead || (m_trail && (bits_q != 4'h0 || sck_out == cs_q[SSP_CS_IDLE_LVL]))) begin
      sck_out <= !sck_out; // RL17
    end
  end

  // ------------------------------------------------------------------
  // Pins
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      sck_oe_n     <= 1'b1;
      sdo          <= 1'b1;
      sdo_oe_n     <= 1'b1;
      pins_claimed <= 1'b0;
    end else begin
      pins_claimed <= enable_q; // RL16
      sck_oe_n     <= !(enable_q && is_master); // RL15 RL16
      sdo_oe_n     <= !(enable_q && (is_master || sel_active)); // RL14
      sdo <= busy ? sh_out : 1'b1; // RL14 RL12
    end
  end

  // ------------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_q   <= SSP_MODE_RST;
      deb_q    <= 2'h0;
      enable_q <= 1'b0;
    end else if (wr_acc && paddr == SSP_ADDR_MODE_CTRL) begin
      mode_q   <= pwdata[SSP_MC_MODE_LSB +: 3]; // RL22
      deb_q    <= pwdata[SSP_MC_DEB_LSB +: 2];
      enable_q <= pwdata[SSP_MC_ENABLE];
    end
  end

  // Hardware set wins over a same-cycle software write
  always_ff @(posedge clk) begin
    if (srst) begin
      incomplete_q <= 1'b0;
    end else if (abort) begin
      incomplete_q <= 1'b1; // RL23
    end else if (wr_acc && paddr == SSP_ADDR_MODE_CTRL) begin
      incomplete_q <= pwdata[SSP_MC_INCOMPLETE];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cs_q <= SSP_CTRL_STATUS_RST;
    end else begin
      if (wr_acc && paddr == SSP_ADDR_CTRL_STATUS) begin
        cs_q <= pwdata[7:0]; // RL21 RL7
      end
      if (data_wr && busy) begin
        cs_q[SSP_CS_WRITE_COLLISION_FLAG] <= 1'b1; // RL6
      end
      if (done || abort) begin
        cs_q[SSP_CS_TRF] <= 1'b1; // RL8 RL23
      end
    end
  end

  // Readable data takes the written byte on a load, and the received byte once the whole byte is in
  always_ff @(posedge clk) begin
    if (srst) begin
      data_q <= 8'h00;
    end else if (sh_load) begin
      data_q <= pwdata[7:0];
    end else if (done) begin
      data_q <= sh_data; // RL18
    end
  end

  // ------------------------------------------------------------------
  // APB slave: zero wait, unmapped reads zero with error
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && paddr != SSP_ADDR_MODE_CTRL
                 && paddr != SSP_ADDR_CTRL_STATUS && paddr != SSP_ADDR_SHIFT_DATA;
      case (paddr)
        SSP_ADDR_MODE_CTRL:   prdata <= {24'h00_0000, mode_q, 1'b0, deb_q, enable_q, incomplete_q};
        SSP_ADDR_CTRL_STATUS: prdata <= {24'h00_0000, cs_q};
        SSP_ADDR_SHIFT_DATA:  prdata <= {24'h00_0000, data_q};
        default:              prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// >>> tb/ssp_monitor.sv
`timescale 1ns/10ps
module ssp_monitor
  import ssp_pkg::*;
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sck_out,
  input wire logic        sck_oe_n,
  input wire logic        sdo_oe_n,
  input wire logic        pins_claimed
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic [4:0] toggles_q;
  logic       sck_prev_q;
  // ------
  // Edge count
  // ------
  // Restart on any write: a write may start or reconfigure a transfer
  always_ff @(posedge clk) begin
    sck_prev_q <= sck_out;
    if (srst || (psel && penable && pwrite)) begin
      toggles_q <= 5'h0;
    end else if (!sck_oe_n && sck_out != sck_prev_q) begin
      toggles_q <= toggles_q + 5'h1;
    end
  end
  reset_state_a: assert property (disable iff (1'b0) srst |=> !pready && !pins_claimed && sck_out && sck_oe_n)
    else $error("outputs not at reset state");
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer in first access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  access_only_a: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  err_cause_a: assert property (pslverr |-> pready && paddr > SSP_ADDR_SHIFT_DATA)
    else $error("error answer on mapped address");
  pins_release_a: assert property (!pins_claimed |-> sck_oe_n && sdo_oe_n)
    else $error("pin driven while disabled");
  enable_cause_a: assert property ($rose(pins_claimed) |-> $past(psel && penable && pwrite, 2))
    else $error("pins claimed without a write");
  bit_count_a: assert property (toggles_q <= 5'h10)
    else $error("more than eight clock pulses");
  sck_hold_a: assert property ($changed(sck_out) && !$past(sck_oe_n) |=> $stable(sck_out))
    else $error("serial clock half period too short");
  full_byte_c: cover property (toggles_q == 5'h10);
  claim_c: cover property ($rose(pins_claimed));
  refuse_c: cover property (pslverr);
endmodule
bind ssp_top ssp_monitor mon (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
  .sck_out, .sck_oe_n, .sdo_oe_n, .pins_claimed);

// >>> tb/ssp_spi_peer.sv
`timescale 1ns/10ps
module ssp_spi_peer (
  input  wire logic  clk,
  input  wire logic  pol,
  input  wire logic  edg,
  input  wire logic  msb,
  input  wire logic  as_master,
  input  wire logic  sck_out,
  input  wire logic  sdo,
  output logic       sck_in,
  output logic       select_n,
  output logic       sdi,
  output logic [7:0] rx
);
  logic [7:0] tx;
  logic       armed;
  int         cnt;
  wire        sck_w = as_master ? sck_in : sck_out;
  initial begin
    sck_in = 1'b1;
    select_n = 1'b1;
    sdi = 1'b0;
    rx = 8'h00;
    armed = 1'b0;
    cnt = 0;
  end
  // ------
  // Shifting
  // ------
  // Data moves only on launch edges so the far end never races its sampling
  always @(sck_w) begin
    if (armed && sck_w == (pol == edg)) begin
      rx <= msb ? {rx[6:0], sdo} : {sdo, rx[7:1]};
      cnt <= cnt + 1;
    end else if (armed && cnt > 0 && cnt < 8) begin
      sdi <= msb ? tx[7-cnt] : tx[cnt];
    end
  end
  task automatic arm(input logic [7:0] b);
    tx = b;
    cnt = 0;
    armed = 1'b1;
    sdi <= msb ? b[7] : b[0];
  endtask
  task automatic release_line();
    armed = 1'b0;
    sdi <= ~sdi;
  endtask
  task automatic run(input int nb);
    sck_in <= ~pol;
    select_n <= 1'b0;
    repeat (6) @(posedge clk);
    repeat (2 * nb) begin
      sck_in <= ~sck_in;
      repeat (6) @(posedge clk);
    end
    select_n <= 1'b1;
  endtask
endmodule

// >>> tb/testbench.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module testbench
  import ssp_pkg::*;
();
  logic        clk, srst, psel, penable, pwrite, sub_tick, tmr_tick;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, sck_in, sck_out, sck_oe_n, sdi, sdo, sdo_oe_n, select_n, pins_claimed;
  logic        pol, edg, msb, as_master;
  logic [7:0]  rx, tx, ptx, cfg;
  logic [2:0]  tk;
  logic [32:0] exp_q[$];
  logic [32:0] ex;
  int          n_fail, samples_checked, cyc;
  ssp_top uut (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sub_tick,
    .tmr_tick, .sck_in, .sck_out, .sck_oe_n, .sdi, .sdo, .sdo_oe_n, .select_n_in(select_n), .pins_claimed);
  ssp_spi_peer peer (.clk, .pol, .edg, .msb, .as_master, .sck_out, .sdo, .sck_in, .select_n, .sdi, .rx);
  always #50 clk = ~clk;
  task automatic final_report();
    $display("checks %0d fails %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    tk <= tk + 3'h1;
    sub_tick <= (tk == 3'h7);
    tmr_tick <= (tk == 3'h3);
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      final_report();
    end
    if (psel && penable && !pwrite && pready === 1'b1) begin
      ex = exp_q.pop_front();
      `CHK("read", ex, {pslverr, prdata})
    end
  end
  // ------
  // Bus tasks
  // ------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    apb(1'b1, a, {24'($urandom), v});
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] v);
    exp_q.push_back({a > SSP_ADDR_SHIFT_DATA, 24'h00_0000, v});
    apb(1'b0, a, 32'h0000_0000);
  endtask
  initial begin
    {clk, psel, penable, pwrite, sub_tick, tmr_tick, pol, edg, msb, as_master} = '0;
    srst = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    tk = 3'h0;
    void'($urandom(30995));
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    rd(SSP_ADDR_MODE_CTRL, 8'hE0);
    rd(SSP_ADDR_CTRL_STATUS, 8'h00);
    wr(SSP_ADDR_CTRL_STATUS, 8'hC0);
    rd(SSP_ADDR_CTRL_STATUS, 8'hC0);
    rd(12'h00C, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      {pol, edg, msb} = 3'(i);
      cfg = {2'b10, pol, edg, msb, 3'b000};
      wr(SSP_ADDR_MODE_CTRL, {3'(i % 5), 5'h00});
      wr(SSP_ADDR_CTRL_STATUS, cfg);
      wr(SSP_ADDR_MODE_CTRL, {3'(i % 5), 5'h02});
      repeat (2) @(posedge clk);
      `CHK("idle_sck", ~pol, sck_out)
      `CHK("sck_oe_n", 1'b0, sck_oe_n)
      tx = 8'($urandom);
      ptx = 8'($urandom);
      peer.arm(ptx);
      wr(SSP_ADDR_SHIFT_DATA, tx);
      if (i == 3) wr(SSP_ADDR_SHIFT_DATA, ~tx);
      for (int k = 0; k < 3000 && peer.cnt < 8; k++) @(posedge clk);
      repeat (100) @(posedge clk);
      rd(SSP_ADDR_CTRL_STATUS, cfg | {6'h00, i == 3, 1'b1});
      rd(SSP_ADDR_SHIFT_DATA, ptx);
      `CHK("peer_rx", tx, rx)
      wr(SSP_ADDR_CTRL_STATUS, cfg);
      rd(SSP_ADDR_CTRL_STATUS, cfg);
      peer.release_line();
      wr(SSP_ADDR_MODE_CTRL, 8'hE0);
      repeat (2) @(posedge clk);
      `CHK("released", 1'b1, sck_oe_n)
    end
    $display("test master done");
    as_master = 1'b1;
    {pol, edg, msb} = 3'b011;
    cfg = 8'h9C;
    wr(SSP_ADDR_MODE_CTRL, 8'hA0);
    wr(SSP_ADDR_CTRL_STATUS, cfg);
    wr(SSP_ADDR_MODE_CTRL, 8'hA2);
    for (int n = 8; n > 0; n -= 5) begin
      tx = 8'($urandom);
      ptx = 8'($urandom);
      wr(SSP_ADDR_SHIFT_DATA, tx);
      peer.arm(ptx);
      peer.run(n);
      peer.release_line();
      repeat (20) @(posedge clk);
      rd(SSP_ADDR_CTRL_STATUS, cfg | 8'h01);
      rd(SSP_ADDR_MODE_CTRL, {7'h51, n < 8});
      if (n == 8) begin
        rd(SSP_ADDR_SHIFT_DATA, ptx);
        `CHK("slave_out", tx, rx)
      end
      wr(SSP_ADDR_CTRL_STATUS, cfg);
    end
    $display("test slave done");
    final_report();
  end
endmodule
